// ===== rtl/psup_pkg.sv
// Package with constants and carrier types for the processor supervisor.
package psup_pkg;

   // Clock rate of ref_clk in Hz.
   localparam int unsigned CLK_HZ = 10000000;

   // Reset hold, debounce and watchdog periods in milliseconds.
   localparam int unsigned HOLD_MS = 250;
   localparam int unsigned WD_SHORT_MS = 250;
   localparam int unsigned WD_MID_MS = 500;
   localparam int unsigned WD_LONG_MS = 1000;

   // Cycle counts derived from the periods; all exceed 4096, so the top module exposes them as parameters.
   localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned WD_MID_CYC = WD_MID_MS * (CLK_HZ / 1000);
   localparam int unsigned WD_LONG_CYC = WD_LONG_MS * (CLK_HZ / 1000);

   // Counter width, wide enough for the longest period.
   localparam int unsigned CNT_W = 24;

   // Timeout-select field of the watchdog period register.
   localparam int unsigned TSEL_LSB_POS = 0;
   localparam int unsigned TSEL_MSB_POS = 1;
   localparam logic [1:0] TSEL_OFF = 2'h0;
   localparam logic [1:0] TSEL_250 = 2'h1;
   localparam logic [1:0] TSEL_500 = 2'h2;
   localparam logic [1:0] TSEL_1000 = 2'h3;
   localparam logic [7:0] WDREG_RESET = 8'h03;
   localparam logic [7:0] WDREG_MASK = 8'h03;

   // Reset sequencer states.
   typedef enum logic [2:0] {
      PSUP_IDLE,
      PSUP_PWR_FAIL,
      PSUP_PWR_HOLD,
      PSUP_OSC_WAIT,
      PSUP_DEBOUNCE,
      PSUP_WAIT_REL,
      PSUP_HOLD
   } psup_state_e;

   // Register write port carrier.
   typedef struct packed {
      logic       we;
      logic [7:0] wdata;
   } psup_regwr_s;

   // Reset line pin carrier: output level and output enable.
   typedef struct packed {
      logic o;
      logic oe;
   } psup_pin_s;

endpackage

// ===== rtl/psup_supervisor.sv
// Processor supervisor: power-fail reset, pushbutton debounce and watchdog on one reset line.
//
// How it works
// - Supply fail forces reset active.
// - Hold reset 250 ms after supply returns.
// - Oscillator disabled adds oscillator start time.
// - Falling edge on idle line: drive low.
// - After 250 ms debounce, await line release.
// - On release drive low another 250 ms.
// - Missing strobe within timeout asserts reset.
// - Select codes: off, 250, 500, 1000 ms.
// - Watchdog counts once reset goes inactive.
// - Watchdog defaults enabled at 1000 ms.
// - Strobe falling edge restarts full period.
// - Watchdog expiry gives 250 ms reset.
// - Oscillator disable stops oscillator, enters standby, only while supply fails.
`timescale 1ns/1ns
// Period lengths are parameters so that a bench can run them in a few cycles.
module psup_supervisor #(
   parameter int unsigned HOLD_CYC     = psup_pkg::HOLD_CYC,
   parameter int unsigned WD_SHORT_CYC = psup_pkg::WD_SHORT_CYC,
   parameter int unsigned WD_MID_CYC   = psup_pkg::WD_MID_CYC,
   parameter int unsigned WD_LONG_CYC  = psup_pkg::WD_LONG_CYC
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  clk_en,
   input  wire logic                  supply_fail,
   input  wire logic                  osc_ready,
   input  wire logic                  watchdog_strobe,
   input  wire logic                  rst_line_i,
   output psup_pkg::psup_pin_s        rst_line,
   input  wire psup_pkg::psup_regwr_s wd_reg_wr,
   output logic [7:0]                 wd_reg_rdata,
   input  wire logic                  oscillator_disable,
   output logic                       osc_stop,
   output logic                       standby,
   output logic                       reset_active
);

   // Sequencer state and its shared period counter.
   psup_pkg::psup_state_e state_q, state_d;
   logic [psup_pkg::CNT_W-1:0] cnt_q, cnt_d;
   // Watchdog countdown, separate so it can run while the sequencer idles.
   logic [psup_pkg::CNT_W-1:0] wd_cnt_q, wd_cnt_d;
   // Timeout-select register bits.
   // Only two bits are stored; the rest of the register reads as zero.
   logic [1:0]                 tsel_q;
   // Previous samples of the reset line and the strobe, for edge detection.
   logic                       line_prev_q;
   logic                       strobe_prev_q;

   // Cycle counts narrowed to counter width once, here.
   // The power hold, the debounce and the expiry reset share one length.
   wire [psup_pkg::CNT_W-1:0] hold_last   = psup_pkg::CNT_W'(HOLD_CYC - 1);
   // Selected watchdog period; code zero never reaches the counter.
   wire [psup_pkg::CNT_W-1:0] wd_period   = (tsel_q == psup_pkg::TSEL_250) ? psup_pkg::CNT_W'(WD_SHORT_CYC) :
                                            (tsel_q == psup_pkg::TSEL_500) ? psup_pkg::CNT_W'(WD_MID_CYC) :
                                            psup_pkg::CNT_W'(WD_LONG_CYC);
   wire                       wd_enabled  = (tsel_q != psup_pkg::TSEL_OFF);
   // Any state but idle is a reset cycle, the release wait included.
   wire                       in_reset    = (state_q != psup_pkg::PSUP_IDLE);
   // Edge detectors compare the last two samples of each pin.
   wire                       line_fall   = line_prev_q & ~rst_line_i;
   wire                       line_rise   = ~line_prev_q & rst_line_i;
   wire                       strobe_fall = strobe_prev_q & ~watchdog_strobe;
   wire                       hold_done   = (cnt_q == hold_last);
   // Expiry is taken at a count of one, so the reset starts as the period ends.
   wire                       wd_expire   = wd_enabled && (wd_cnt_q == psup_pkg::CNT_W'(1));

   // The register reads back only the two select bits; the rest read as zero.
   assign wd_reg_rdata = {6'h00, tsel_q};
   // The line is driven low in every state but idle and the release wait, where the button holds it.
   // The pin is open drain: it only ever pulls low and never drives high.
   assign rst_line.o   = 1'b0;
   assign rst_line.oe  = in_reset && (state_q != psup_pkg::PSUP_WAIT_REL);
   // The reset_active output mirrors the sequencer, release wait included.
   assign reset_active = in_reset;
   // Oscillator stop and standby only take effect while the supply is failing, i.e. on battery.
   // On a good supply the oscillator keeps running whatever the control bit says.
   assign osc_stop     = oscillator_disable & supply_fail;
   assign standby      = oscillator_disable & supply_fail;

   // Sequencer next-state logic; supply fail overrides every other source.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + psup_pkg::CNT_W'(1);
      case (state_q)
         // Idle: watch the line and the watchdog.
         psup_pkg::PSUP_IDLE: begin
            cnt_d = '0;
            // A button press wins over an expiry in the same cycle.
            if (line_fall) begin
               state_d = psup_pkg::PSUP_DEBOUNCE;
            end else if (wd_expire) begin
               state_d = psup_pkg::PSUP_HOLD;
            end
         end
         // Supply out of tolerance: reset held with no time limit.
         psup_pkg::PSUP_PWR_FAIL: begin
            cnt_d = '0;
            // Stay here for as long as the supply is bad.
            if (!supply_fail) begin
               state_d = psup_pkg::PSUP_PWR_HOLD;
            end
         end
         // Supply back: hold reset so that supply and processor settle.
         psup_pkg::PSUP_PWR_HOLD: begin
            // The hold ends after its full length has passed.
            if (hold_done) begin
               cnt_d   = '0;
               // With the oscillator disabled, wait further for it to start.
               state_d = oscillator_disable ? psup_pkg::PSUP_OSC_WAIT : psup_pkg::PSUP_IDLE;
            end
         end
         // Oscillator was stopped: extend the hold until it runs.
         psup_pkg::PSUP_OSC_WAIT: begin
            cnt_d = '0;
            // No time limit: a dead oscillator keeps the processor in reset.
            if (osc_ready) begin
               state_d = psup_pkg::PSUP_IDLE;
            end
         end
         // Button seen: pull the line low while contacts bounce.
         psup_pkg::PSUP_DEBOUNCE: begin
            // Bounces during this time are hidden by our own drive.
            if (hold_done) begin
               cnt_d = '0;
               // Sample the line: still low means the button is held.
               state_d = rst_line_i ? psup_pkg::PSUP_IDLE : psup_pkg::PSUP_WAIT_REL;
            end
         end
         // Button still held: let go of the line and wait.
         psup_pkg::PSUP_WAIT_REL: begin
            cnt_d = '0;
            // The button holds the line; its rising edge marks release.
            if (line_rise) begin
               state_d = psup_pkg::PSUP_HOLD;
            end
         end
         // Final hold after a release or a watchdog expiry.
         psup_pkg::PSUP_HOLD: begin
            // Let go of the line once the full hold length has passed.
            if (hold_done) begin
               cnt_d   = '0;
               state_d = psup_pkg::PSUP_IDLE;
            end
         end
         // Unused codes recover to idle.
         default: begin
            cnt_d   = '0;
            state_d = psup_pkg::PSUP_IDLE;
         end
      endcase
      // Supply fail is applied last so that it wins over every other source.
      // The counter stays cleared so the power hold starts from zero on return.
      if (supply_fail) begin
         cnt_d   = '0;
         state_d = psup_pkg::PSUP_PWR_FAIL;
      end
   end

   // Watchdog countdown: reload on strobe fall, cleared during reset.
   always_comb begin
      wd_cnt_d = wd_cnt_q;
      // Counting stops in reset, so a strobe seen there cannot shorten a later period.
      if (in_reset || !wd_enabled) begin
         wd_cnt_d = '0;
      // An empty count means the first idle cycle: load the full period.
      end else if (wd_cnt_q == '0 || strobe_fall) begin
         wd_cnt_d = wd_period;
      // Otherwise count down one cycle at a time.
      end else begin
         wd_cnt_d = wd_cnt_q - psup_pkg::CNT_W'(1);
      end
   end

   // Sequencer registers; reset comes up in power-fail so the hold runs from power-on.
   // A low clk_en holds every register, so all periods stretch with it.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= psup_pkg::PSUP_PWR_FAIL;
         cnt_q   <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Watchdog counter register.
   // Cleared in reset, so the first idle cycle reloads the full period.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wd_cnt_q <= '0;
      end else if (clk_en) begin
         wd_cnt_q <= wd_cnt_d;
      end
   end

   // Edge detector samples; the line idles high through its pullup.
   // Resetting to the idle level avoids a false edge after reset.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         line_prev_q   <= 1'b1;
         strobe_prev_q <= 1'b1;
      end else if (clk_en) begin
         line_prev_q   <= rst_line_i;
         strobe_prev_q <= watchdog_strobe;
      end
   end

   // Timeout-select register; defaults to the longest period, enabled.
   // Writes take only the two select bits; the upper bits are dropped.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tsel_q <= psup_pkg::WDREG_RESET[1:0];
      end else if (clk_en && wd_reg_wr.we) begin
         tsel_q <= wd_reg_wr.wdata[psup_pkg::TSEL_MSB_POS:psup_pkg::TSEL_LSB_POS];
      end
   end

endmodule

// ===== dv/psup_chk.sv
// Assertion checker watching the processor supervisor's ports.
`timescale 1ns/1ns
module psup_chk (
   input wire logic                  ref_clk,
   input wire logic                  rst,
   input wire logic                  supply_fail,
   input wire logic                  rst_line_i,
   input wire psup_pkg::psup_pin_s   rst_line,
   input wire psup_pkg::psup_regwr_s wd_reg_wr,
   input wire logic [7:0]            wd_reg_rdata,
   input wire logic                  oscillator_disable,
   input wire logic                  osc_stop,
   input wire logic                  standby,
   input wire logic                  reset_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_fail_forces: assert property (supply_fail |=> rst_line.oe && reset_active) else $error("no reset on fail");
   a_line_low: assert property (rst_line.oe |-> !rst_line.o && reset_active) else $error("bad drive level");
   a_button_edge: assert property (!reset_active && $past(rst_line_i) && !rst_line_i |=> rst_line.oe)
      else $error("edge not held low");
   a_release_hold: assert property (reset_active && !rst_line.oe && rst_line_i |=> rst_line.oe)
      else $error("release not held");
   a_select_wr: assert property (wd_reg_wr.we |=> wd_reg_rdata == ($past(wd_reg_wr.wdata) & 8'h03))
      else $error("select write lost");
   a_select_keep: assert property (!wd_reg_wr.we |=> $stable(wd_reg_rdata)) else $error("select drifted");
   a_standby_out: assert property (osc_stop == (oscillator_disable && supply_fail) && standby == osc_stop)
      else $error("standby mismatch");
   a_fail_active: assert property (supply_fail [*2] |-> reset_active) else $error("fail not active");
   c_button: cover property (!reset_active && $past(rst_line_i) && !rst_line_i);
   c_wait_rel: cover property (reset_active && !rst_line.oe);
   c_write: cover property (wd_reg_wr.we);
endmodule
bind psup_supervisor psup_chk u_chk (.ref_clk(ref_clk), .rst(rst), .supply_fail(supply_fail),
   .rst_line_i(rst_line_i), .rst_line(rst_line), .wd_reg_wr(wd_reg_wr), .wd_reg_rdata(wd_reg_rdata),
   .oscillator_disable(oscillator_disable), .osc_stop(osc_stop), .standby(standby), .reset_active(reset_active));

// ===== dv/psup_host.sv
// Host processor and pushbutton model on the far side of the reset line.
`timescale 1ns/1ns
module psup_host (
   input  wire logic ref_clk,
   input  wire logic kick_en,
   input  wire logic press,
   input  wire logic drive_low,
   output logic      watchdog_strobe,
   output logic      rst_line_i
);
   logic [2:0] div_q = 3'h0; // Toggle every 8 cycles keeps falls well inside the shortest timeout.
   logic       strobe_q = 1'b1; // Strobe idles high, so the first toggle is a falling edge.
   assign watchdog_strobe = strobe_q;
   // The pull-up wins only while neither the button nor the device pulls low.
   assign rst_line_i = !(drive_low || press);
   // Software kicks the watchdog only while enabled, so a stall is a real stall.
   always @(posedge ref_clk) begin
      div_q <= div_q + 3'h1;
      if (kick_en && div_q == 3'h7) begin
         strobe_q <= !strobe_q;
      end
   end
endmodule

// ===== dv/tb_processor_supervisor.sv
// Self-checking testbench for the processor supervisor.
`timescale 1ns/1ns
module tb_processor_supervisor;
   localparam int HOLD = 20;
   localparam int PER[4] = '{0, 30, 60, 120};
   logic                  ref_clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  fail = 1'b0;
   logic                  osc_rdy = 1'b1;
   logic                  osc_off = 1'b0;
   logic                  kick = 1'b0;
   logic                  press = 1'b0;
   logic                  strobe;
   logic                  line_i;
   psup_pkg::psup_pin_s   line;
   psup_pkg::psup_regwr_s wr_s = '0;
   logic [7:0]            rdata;
   logic                  active;
   logic                  run = 1'b1;
   logic                  stop;
   logic                  stby;
   int                    fails = 0;
   int                    tests_run = 0;
   int                    n;
   psup_supervisor #(.HOLD_CYC(HOLD), .WD_SHORT_CYC(PER[1]), .WD_MID_CYC(PER[2]), .WD_LONG_CYC(PER[3])) DUT (
      .ref_clk(ref_clk), .rst(rst), .clk_en(run), .supply_fail(fail), .osc_ready(osc_rdy), .watchdog_strobe(strobe),
      .rst_line_i(line_i), .rst_line(line), .wd_reg_wr(wr_s), .wd_reg_rdata(rdata), .oscillator_disable(osc_off),
      .osc_stop(stop), .standby(stby), .reset_active(active));
   psup_host u_host (.ref_clk(ref_clk), .kick_en(kick), .press(press), .drive_low(line.oe),
      .watchdog_strobe(strobe), .rst_line_i(line_i));
   initial forever #50 ref_clk = ~ref_clk;
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Counts cycles, at most 300, that reset_active keeps level lvl; the count must fall in lo..hi.
   task automatic span(input logic lvl, input int lo, input int hi);
      n = 0;
      while (active === lvl && n < 300) begin
         tick(1);
         n++;
      end
      tests_run++;
      if (n < lo || n > hi) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, n, lo);
      end
   endtask
   // Writes v and checks that only its two select bits read back.
   task automatic wr(input logic [7:0] v);
      @(posedge ref_clk);
      wr_s <= '{1'b1, v};
      @(posedge ref_clk);
      wr_s <= '0;
      tick(1);
      chk(rdata, v & 8'h03);
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // The whole sequence needs under 2500 cycles, so 6000 means a hang.
   initial begin
      repeat (6000) @(posedge ref_clk);
      fails++;
      stop_test();
   end
   initial begin
      tick(5);
      chk(rdata, 8'h03);
      @(posedge ref_clk);
      rst <= 1'b0;
      span(1'b1, HOLD, HOLD + 2);
      span(1'b0, PER[3], PER[3] + 2);
      // Each select is written during the hold, so the next idle span runs on it.
      for (int s = 1; s < 4; s++) begin
         wr(8'hfc | 8'(s));
         span(1'b1, HOLD - 5, HOLD);
         span(1'b0, PER[s], PER[s] + 2);
      end
      wr(8'h01);
      kick <= 1'b1;
      span(1'b1, HOLD - 5, HOLD);
      span(1'b0, 300, 300);
      wr(8'h00);
      kick <= 1'b0;
      span(1'b0, 300, 300);
      press <= 1'b1;
      tick(2);
      chk(8'(line.oe), 8'h01);
      tick(HOLD + 3);
      chk(8'({line.oe, active}), 8'h01);
      press <= 1'b0;
      tick(2);
      chk(8'(line.oe), 8'h01);
      span(1'b1, HOLD - 3, HOLD);
      fail <= 1'b1;
      osc_off <= 1'b1;
      osc_rdy <= 1'b0;
      tick(2);
      chk(8'(line.oe), 8'h01);
      chk(8'({stop, stby}), 8'h03);
      fail <= 1'b0;
      tick(HOLD + 10);
      chk(8'(active), 8'h01);
      chk(8'({stop, stby}), 8'h00);
      // With the clock enable low the start report must not end the reset.
      run <= 1'b0;
      osc_rdy <= 1'b1;
      tick(3);
      chk(8'(active), 8'h01);
      run <= 1'b1;
      span(1'b1, 0, 3);
      // A second reset in mid-run restores the default select and the power-up hold.
      rst <= 1'b1;
      tick(2);
      chk(rdata, 8'h03);
      chk(8'({line.oe, active}), 8'h03);
      @(posedge ref_clk);
      rst <= 1'b0;
      span(1'b1, HOLD, HOLD + 2);
      span(1'b0, PER[3], PER[3] + 2);
      stop_test();
   end
endmodule
